// ===== hdl/cfg_loader_defs.vh
// constants for the serial configuration chain loader
// Functional notes
// - capture serial bit on clock rise while enabled
// - setup registers shift one place per bit
// - loaded and enabled: serial input passes to output
// - serial output carries stream down the chain
// - enable output follows enable input once loaded
// - enable output low means ready for operation
`ifndef CFG_LOADER_DEFS_VH
`define CFG_LOADER_DEFS_VH
`define CFG_LEN       16'h0040
`define CFG_LEN_W     16
`define CFG_STEP      16'h0001
`define CFG_LAST      (`CFG_LEN - `CFG_STEP)
`define CFG_KEEP_MSB  (`CFG_LEN - 16'h0002)
`define ST_W          1
`define PIN_IDLE      1'h1
`define OUT_QUIET     1'h0
`define EN_OFF        1'h1
`define DONE_CLR      1'h0
`define DONE_SET      1'h1
`define BIT_CLR       1'h0
`define SYNC_SECOND   1
`define SYNC_THIRD    2
`define SYNC_RESET    3'h7
`define SYNC_DEPTH    3
`define ST_LOAD       1'h0
`define ST_DONE       1'h1
`endif

// ===== hdl/pin_sync.v
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
`include "cfg_loader_defs.vh"
module pin_sync (
   // clock and reset
   input  wire clk,
   input  wire rst_b,
   // pin side
   input  wire pinIn,
   // filtered level
   output reg  levelOut
);
   reg [`SYNC_DEPTH-1:0] stage_ff;

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stage_ff <= `SYNC_RESET;
         levelOut <= `PIN_IDLE;
      end else begin
         stage_ff <= {stage_ff[`SYNC_SECOND:0], pinIn};
         // change counts once stage two and three agree
         if (stage_ff[`SYNC_SECOND] == stage_ff[`SYNC_THIRD]) begin
            levelOut <= stage_ff[`SYNC_THIRD];
         end
      end
   end
endmodule
`default_nettype wire

// ===== hdl/serial_config_chain_loader.v
// device-side serial configuration loader with chain pass-through
`timescale 1ns/100ps
`default_nettype none
`include "cfg_loader_defs.vh"
module serial_config_chain_loader (
   // clock and reset
   input  wire                 clk,
   input  wire                 rst_b,
   // serial link pins
   input  wire                 serialClk,
   input  wire                 serialIn,
   input  wire                 chainEnableIn_n,
   // serial link outputs
   output reg                  serialOut,
   output reg                  chainEnableOut_n,
   // configuration image and status
   output reg  [`CFG_LEN-1:0]  setupBits,
   output reg                  configDone
);
   ////////////////////////////////////////////////////////////////////
   // load states
   localparam [`ST_W-1:0] ST_LOAD = `ST_LOAD;
   localparam [`ST_W-1:0] ST_DONE = `ST_DONE;

   ////////////////////////////////////////////////////////////////////
   // filtered pin levels
   wire                  sclkLvl;
   wire                  dataLvl;
   wire                  enLvl;
   // serial clock edge detect
   reg                   sclkPrev_ff;
   wire                  sclkRise;
   // bit sequencing
   reg  [`ST_W-1:0]      state_ff;
   reg  [`ST_W-1:0]      nxt_state;
   reg  [`CFG_LEN_W-1:0] count_ff;
   reg  [`CFG_LEN_W-1:0] nxt_count;
   wire                  takeBit;
   wire                  lastBit;
   wire                  forwarding;
   // next values of the output flops
   reg  [`CFG_LEN-1:0]   nxt_setupBits;
   reg                   nxt_configDone;
   reg                   nxt_serialOut;
   reg                   nxt_chainEnableOut_n;

   ////////////////////////////////////////////////////////////////////
   // one place shift of the image, newest bit at the bottom
   function [`CFG_LEN-1:0] shiftIn;
      input [`CFG_LEN-1:0] image;
      input                bitIn;
      begin
         shiftIn = {image[`CFG_KEEP_MSB:0], bitIn};
      end
   endfunction

   // bit counter step
   function [`CFG_LEN_W-1:0] countUp;
      input [`CFG_LEN_W-1:0] value;
      begin
         countUp = value + `CFG_STEP;
      end
   endfunction

   // forwarded bit, quiet level while not passing through
   function passBit;
      input enable;
      input bitIn;
      begin
         passBit = enable ? bitIn : `OUT_QUIET;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers; data and enable see the same depth as the clock
   pin_sync uSyncClk (
      .clk      (clk),
      .rst_b    (rst_b),
      .pinIn    (serialClk),
      .levelOut (sclkLvl)
   );
   pin_sync uSyncData (
      .clk      (clk),
      .rst_b    (rst_b),
      .pinIn    (serialIn),
      .levelOut (dataLvl)
   );
   pin_sync uSyncEn (
      .clk      (clk),
      .rst_b    (rst_b),
      .pinIn    (chainEnableIn_n),
      .levelOut (enLvl)
   );

   ////////////////////////////////////////////////////////////////////
   // edge detect; idle high like the synchroniser reset, so no false edge
   assign sclkRise   = sclkLvl & ~sclkPrev_ff;
   assign takeBit    = sclkRise & ~enLvl;
   assign lastBit    = (count_ff == `CFG_LAST);
   assign forwarding = ~enLvl;

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sclkPrev_ff <= `PIN_IDLE;
      end else begin
         sclkPrev_ff <= sclkLvl;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // load sequencing: count bits, stop after the last one
   always @* begin
      nxt_state = state_ff;
      nxt_count = count_ff;
      case (state_ff)
         ST_LOAD: begin
            // bits refused while enable in is high
            if (takeBit) begin
               if (lastBit) begin
                  nxt_state = ST_DONE;
               end else begin
                  nxt_count = countUp(count_ff);
               end
            end
         end
         ST_DONE: begin
            nxt_state = ST_DONE;
         end
         default: begin
            nxt_state = ST_LOAD;
         end
      endcase
   end

   // state register
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= ST_LOAD;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // bit counter
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         count_ff <= {`CFG_LEN_W{`BIT_CLR}};
      end else begin
         count_ff <= nxt_count;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // output next values
   // pass-through is registered so every output leaves a flop
   always @* begin
      nxt_setupBits        = setupBits;
      nxt_configDone       = configDone;
      nxt_serialOut        = `OUT_QUIET;
      nxt_chainEnableOut_n = `EN_OFF;
      case (state_ff)
         ST_LOAD: begin
            nxt_serialOut        = `OUT_QUIET;
            nxt_chainEnableOut_n = `EN_OFF;
            if (takeBit) begin
               nxt_setupBits  = shiftIn(setupBits, dataLvl);
               nxt_configDone = lastBit;
            end
         end
         ST_DONE: begin
            // image full: no more shifting, enable out follows enable in
            nxt_configDone       = `DONE_SET;
            nxt_chainEnableOut_n = enLvl;
            nxt_serialOut        = passBit(forwarding, dataLvl);
         end
         default: begin
            // unreachable; back to an empty image
            nxt_setupBits  = {`CFG_LEN{`BIT_CLR}};
            nxt_configDone = `DONE_CLR;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // output flops
   // serial pass-through
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         serialOut <= `OUT_QUIET;
      end else begin
         serialOut <= nxt_serialOut;
      end
   end

   // chain enable out
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         chainEnableOut_n <= `EN_OFF;
      end else begin
         chainEnableOut_n <= nxt_chainEnableOut_n;
      end
   end

   // setup image
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         setupBits <= {`CFG_LEN{`BIT_CLR}};
      end else begin
         setupBits <= nxt_setupBits;
      end
   end

   // load complete flag
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         configDone <= `DONE_CLR;
      end else begin
         configDone <= nxt_configDone;
      end
   end
endmodule
`default_nettype wire

// ===== sim/cfg_loader_assertions.sv
// assertions on the chain loader ports
`timescale 1ns/100ps
`default_nettype none
module cfg_loader_assertions (input wire logic clk, rst_b, serialIn, chainEnableIn_n,
   serialOut, chainEnableOut_n, configDone, input wire logic [63:0] setupBits);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   chk_shift_one: assert property ($changed(setupBits) |->
      setupBits[63:1] == $past(setupBits[62:0])) else $error("shift");
   chk_off_hold: assert property (chainEnableIn_n [*8] |=>
      $stable(setupBits)) else $error("hold");
   chk_en_follow: assert property ((configDone && $stable(chainEnableIn_n)) [*8] |=>
      chainEnableOut_n == $past(chainEnableIn_n)) else $error("follow");
   chk_ready_done: assert property (!chainEnableOut_n |-> configDone) else $error("ready");
   chk_pass_bit: assert property ((configDone && !chainEnableIn_n && $stable(serialIn)) [*6]
      |-> serialOut == serialIn) else $error("pass");
   chk_out_quiet: assert property (!configDone |-> !serialOut) else $error("quiet");
   cover property ($rose(configDone));
   cover property ($fell(chainEnableOut_n));
   cover property ($rose(chainEnableOut_n));
endmodule
bind serial_config_chain_loader cfg_loader_assertions i_chk (.*);
`default_nettype wire

// ===== sim/cfg_ctrl_model.sv
// configuration controller driving the serial pins
`timescale 1ns/100ps
`default_nettype none
module cfg_ctrl_model (input wire logic clk, output var logic serialClk = 1'h1,
   serialIn = 1'h1, chainEnableIn_n = 1'h1);
   // one bit per 800 ns frame; data inverted once its hold is over
   task put(input logic b, e);
      @(posedge clk) serialIn <= b;
      chainEnableIn_n <= e;
      serialClk <= 1'h0;
      repeat (4) @(posedge clk);
      serialClk <= 1'h1;
      repeat (3) @(posedge clk);
      serialIn <= ~b;
   endtask
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// self-checking bench for the chain loader
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic clk = 1'h0, rst_b = 1'h0, b;
   logic serialClk, serialIn, chainEnableIn_n, serialOut, chainEnableOut_n, configDone;
   logic [63:0] setupBits, expBits = 64'h0;
   wire [66:0] seen = {setupBits, serialOut, chainEnableOut_n, configDone};
   integer seed = 32'h3cd8968a, mismatches = 0, n_compared = 0, i;
   always #50 clk = ~clk;
   cfg_ctrl_model i_ctl (.*);
   serial_config_chain_loader i_dut (.*);
   function automatic logic [66:0] expectAt(input integer k, input logic bitIn);
      expectAt = {expBits, (k > 71) & bitIn, k < 72, k > 71};
   endfunction
   task chk(input logic [66:0] got, exp);
      n_compared++;
      mismatches += (got !== exp);
      if (got !== exp) $display("MISMATCH %0t %h %h", $time, got, exp);
   endtask
   task results;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      #200000 mismatches++;
      results;
   end
   // 8 refused bits, 64 loaded, 8 passed through after loading
   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1'h1;
      for (i = 0; i < 80; i++) begin
         b = $random(seed);
         i_ctl.put(b, i < 8);
         #1 chk(seen, expectAt(i, b));
         if (i > 7 && i < 72) expBits = {expBits[62:0], b};
      end
      chk(seen, {expBits, b, 2'h1});
      i_ctl.put(1'h0, 1'h1);
      #1 chk(seen, {expBits, 3'h3});
      results;
   end
endmodule
`default_nettype wire
